// ==== shared/ssb_pkg.sv ====
package ssb_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // clock and timing
   localparam int CLK_NS = 4;
   // select low to first rising serial clock, active device
   localparam int T_SP_NS = 20;
   localparam int T_SP_CYC = (T_SP_NS + CLK_NS - 1) / CLK_NS;
   // select low to first rising serial clock, waking from power-down
   localparam int T_WAKE_US = 150;
   localparam int T_WAKE_CYC = (T_WAKE_US * 1000 + CLK_NS - 1) / CLK_NS;
   // last falling serial clock to select release
   localparam int T_NS_NS = 20;
   localparam int T_NS_CYC = (T_NS_NS + CLK_NS - 1) / CLK_NS;
   // serial clock ceiling for back-to-back bytes
   localparam int SCLK_MAX_KHZ = 6500;
   localparam int SCLK_HALF_CYC = (1000000 + 2 * SCLK_MAX_KHZ * CLK_NS - 1)
                                  / (2 * SCLK_MAX_KHZ * CLK_NS);
   localparam logic [15:0] HALF_LAST = 16'(SCLK_HALF_CYC - 1);
   localparam logic [15:0] TSP_LAST = 16'(T_SP_CYC - 1);
   localparam logic [15:0] TNS_LAST = 16'(T_NS_CYC - 1);

   ////////////////////////////////////////////////////////////////////////////
   // status byte layout
   localparam int ST_RDY_BIT = 7;
   localparam int ST_CODE_HI = 6;
   localparam int ST_CODE_LO = 4;
   localparam int ST_FREE_HI = 3;
   localparam logic [3:0] FREE_SAT = 4'hf;
   localparam logic [2:0] BIT_LAST = 3'h7;

   // main state codes
   typedef logic [2:0] ssb_code_t;
   localparam ssb_code_t CODE_IDLE = 3'h0;
   localparam ssb_code_t CODE_TX = 3'h2;
   localparam ssb_code_t CODE_SYNTH_ON = 3'h3;
   localparam ssb_code_t CODE_CAL = 3'h4;
   localparam ssb_code_t CODE_SETTLE = 3'h5;
   localparam ssb_code_t CODE_UNDERRUN = 3'h7;

   // header byte layout
   localparam int HDR_RW_BIT = 7;
   localparam int HDR_BURST_BIT = 6;
   localparam int HDR_ADDR_HI = 5;
   // strobe address of the queue flush, value arbitrary
   localparam logic [5:0] FLUSH_ADDR = 6'h30;

   ////////////////////////////////////////////////////////////////////////////
   // host controller register map (byte addresses)
   localparam logic [7:0] REG_TXD = 8'h00;
   localparam logic [7:0] REG_RXD = 8'h04;
   localparam logic [7:0] REG_CTRL = 8'h08;
   localparam logic [7:0] REG_STAT = 8'h0c;
   localparam logic [7:0] REG_IRQ = 8'h10;
   localparam logic [7:0] REG_MASK = 8'h14;
   localparam int TXD_LAST_BIT = 8;
   localparam int CTRL_NOPOLL_BIT = 0;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_PEND_BIT = 1;
   localparam int STAT_SEL_BIT = 2;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_UNDERRUN_BIT = 1;
   localparam int IRQ_W = 2;

endpackage : ssb_pkg

// ==== shared/ssb_link_if.sv ====
// four-wire serial link; the serial output idles high when not driven
interface ssb_link_if;
   logic sclk;
   logic select_low;
   logic mosi;
   logic miso;
   logic miso_oe;
   logic so_line;

   // pull-up on the shared output line
   assign so_line = miso_oe ? miso : 1'b1;

   modport dev (
      input sclk,
      input select_low,
      input mosi,
      output miso,
      output miso_oe
   );

   modport host (
      output sclk,
      output select_low,
      output mosi,
      input so_line
   );
endinterface : ssb_link_if

// ==== verilog/ssb_status_dev.sv ====
module ssb_status_dev (
   input wire logic hclk,
   input wire logic hresetn,
   ssb_link_if.dev link,
   input wire logic crystal_not_ready,
   input wire logic [2:0] main_state,
   input wire logic state_transitional,
   input wire logic [6:0] tx_free,
   input wire logic tx_queue_underrun,
   output logic rx_valid,
   output logic rx_header,
   output logic [7:0] rx_data,
   output logic [5:0] rx_addr,
   output logic rx_burst,
   output logic rx_rw,
   output logic flush_tx_strobe,
   output logic underrun_flag
);

   ////////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      logic [1:0] sclk_s;
      logic [1:0] sel_s;
      logic [1:0] mosi_s;
      logic sclk_q;
      logic [7:0] out_sh;
      logic [7:0] in_sh;
      logic [2:0] bit_cnt;
      logic started;
      logic in_data;
      logic rw;
      logic burst;
      logic [5:0] addr;
      logic underrun;
      logic [7:0] rx_data;
      logic rx_valid;
      logic rx_header;
      logic flush;
   } ssb_dev_state_t;

   localparam ssb_dev_state_t DEV_RESET = '{
      sclk_s: 2'h0,
      sel_s: 2'h3,
      mosi_s: 2'h0,
      sclk_q: 1'b0,
      out_sh: 8'hff,
      in_sh: 8'h00,
      bit_cnt: 3'h0,
      started: 1'b0,
      in_data: 1'b0,
      rw: 1'b0,
      burst: 1'b0,
      addr: 6'h00,
      underrun: 1'b0,
      rx_data: 8'h00,
      rx_valid: 1'b0,
      rx_header: 1'b0,
      flush: 1'b0
   };

   ssb_dev_state_t r;
   ssb_dev_state_t next_r;

   logic sclk_sync;
   logic sel_active;
   logic mosi_sync;
   logic sclk_rise;
   logic sclk_fall;
   logic [7:0] byte_in;
   logic [3:0] free_cnt;
   ssb_pkg::ssb_code_t code;
   logic [7:0] status;
   logic is_flush;

   ////////////////////////////////////////////////////////////////////////////
   // synchronised link view; only the second stage is looked at
   assign sclk_sync = r.sclk_s[1];
   assign sel_active = ~r.sel_s[1];
   assign mosi_sync = r.mosi_s[1];
   assign sclk_rise = sclk_sync & ~r.sclk_q;
   assign sclk_fall = ~sclk_sync & r.sclk_q;
   // msb first: new bits enter at the bottom
   // msb first in
   assign byte_in = {r.in_sh[6:0], mosi_sync};

   ////////////////////////////////////////////////////////////////////////////
   // status byte assembly

   assign free_cnt = (tx_free > 7'(ssb_pkg::FREE_SAT)) ? ssb_pkg::FREE_SAT : tx_free[3:0];

   // unused codes are never passed on; they fall back to idle
   always_comb begin
      if (r.underrun) begin
         code = ssb_pkg::CODE_UNDERRUN;
      end else begin
         case (main_state)
            ssb_pkg::CODE_TX,
            ssb_pkg::CODE_SYNTH_ON,
            ssb_pkg::CODE_UNDERRUN: begin
               code = main_state;
            end
            ssb_pkg::CODE_CAL,
            ssb_pkg::CODE_SETTLE: begin
               code = state_transitional ? ssb_pkg::CODE_IDLE : main_state;
            end
            default: begin
               code = ssb_pkg::CODE_IDLE;
            end
         endcase
      end
   end

   always_comb begin
      status = 8'h00;
      status[ssb_pkg::ST_RDY_BIT] = crystal_not_ready;
      status[ssb_pkg::ST_CODE_HI:ssb_pkg::ST_CODE_LO] = code;
      status[ssb_pkg::ST_FREE_HI:0] = free_cnt;
   end

   assign is_flush = (byte_in[ssb_pkg::HDR_ADDR_HI:0] == ssb_pkg::FLUSH_ADDR)
                     & ~byte_in[ssb_pkg::HDR_BURST_BIT]
                     & ~byte_in[ssb_pkg::HDR_RW_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      next_r = r;
      next_r.sclk_s = {r.sclk_s[0], link.sclk};
      next_r.sel_s = {r.sel_s[0], link.select_low};
      next_r.mosi_s = {r.mosi_s[0], link.mosi};
      next_r.sclk_q = sclk_sync;
      next_r.rx_valid = 1'b0;
      next_r.flush = 1'b0;

      if (!sel_active) begin
         next_r.bit_cnt = 3'h0;
         next_r.started = 1'b0;
         next_r.in_data = 1'b0;
         next_r.out_sh = status;
      end else begin
         // before the first clock the line tracks the live flag so the
         // host can watch the crystal come up
         // live readiness before clocking
         if (!r.started && !sclk_rise) begin
            next_r.out_sh = status;
         end
         if (sclk_rise) begin
            next_r.started = 1'b1;
            next_r.in_sh = byte_in;
            next_r.bit_cnt = r.bit_cnt + 3'h1;
            if (r.bit_cnt == ssb_pkg::BIT_LAST) begin
               next_r.rx_valid = 1'b1;
               next_r.rx_data = byte_in;
               next_r.rx_header = ~r.in_data;
               if (!r.in_data) begin
                  next_r.rw = byte_in[ssb_pkg::HDR_RW_BIT];
                  next_r.burst = byte_in[ssb_pkg::HDR_BURST_BIT];
                  next_r.addr = byte_in[ssb_pkg::HDR_ADDR_HI:0];
                  // a strobe is a lone header; the next byte is a header
                  next_r.flush = is_flush;
                  next_r.in_data = ~is_flush;
               end else begin
                  // single access ends after one data byte
                  next_r.in_data = r.burst;
               end
            end
         end
         if (sclk_fall) begin
            if (r.bit_cnt == 3'h0) begin
               next_r.out_sh = status;
            end else begin
               next_r.out_sh = {r.out_sh[6:0], 1'b0};
            end
         end
      end

      // set wins over the acknowledging flush
      // sticky until flush
      if (r.flush) begin
         next_r.underrun = 1'b0;
      end
      if (tx_queue_underrun) begin
         next_r.underrun = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= DEV_RESET;
      end else begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs; the line is released while select is high
   // msb first out
   assign link.miso = r.out_sh[7];
   assign link.miso_oe = sel_active;
   assign rx_valid = r.rx_valid;
   assign rx_header = r.rx_header;
   assign rx_data = r.rx_data;
   assign rx_addr = r.addr;
   assign rx_burst = r.burst;
   assign rx_rw = r.rw;
   assign flush_tx_strobe = r.flush;
   assign underrun_flag = r.underrun;

endmodule : ssb_status_dev

// ==== verilog/ssb_status_host.sv ====
// serial master: software queues bytes over AHB-Lite, status bytes return
module ssb_status_host #(
   parameter int WAKE_CYC = ssb_pkg::T_WAKE_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   ssb_link_if.host link,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic irq
);

   typedef enum logic [5:0] {
      H_IDLE = 6'h01,
      H_SETUP = 6'h02,
      H_LOW = 6'h04,
      H_HIGH = 6'h08,
      H_GAP = 6'h10,
      H_HOLD = 6'h20
   } ssb_hstate_t;

   typedef struct packed {
      ssb_hstate_t st;
      logic a_wr;
      logic [7:0] a_addr;
      logic [8:0] txd;
      logic pend;
      logic last;
      logic nopoll;
      logic [7:0] rxd;
      logic [ssb_pkg::IRQ_W-1:0] irq_st;
      logic [ssb_pkg::IRQ_W-1:0] mask;
      logic [15:0] cnt;
      logic [2:0] bit_cnt;
      logic [7:0] tx_sh;
      logic [7:0] rx_sh;
      logic sclk;
      logic sel_low;
      logic mosi;
      logic [1:0] miso_s;
   } ssb_host_state_t;

   ssb_host_state_t r;
   ssb_host_state_t next_r;
   logic miso_sync;
   logic go;
   logic [ssb_pkg::IRQ_W-1:0] ev;

   assign miso_sync = r.miso_s[1];

   ////////////////////////////////////////////////////////////////////////////
   // bus, sequencer and events in one pass
   always_comb begin
      next_r = r;
      next_r.miso_s = {r.miso_s[0], link.so_line};
      ev = '0;
      go = 1'b0;
      next_r.cnt = r.cnt + 16'h1;

      // address latched every cycle so the data phase never relies on haddr
      next_r.a_wr = hsel & htrans[1] & hready & hwrite;
      next_r.a_addr = haddr[7:0];

      case (r.st)
         H_IDLE: begin
            next_r.cnt = 16'h0;
            if (r.pend) begin
               next_r.sel_low = 1'b0;
               next_r.st = H_SETUP;
            end
         end
         H_SETUP: begin
            if (r.nopoll) begin
               go = (r.cnt >= 16'(WAKE_CYC - 1));
            end else begin
               go = (r.cnt >= ssb_pkg::TSP_LAST) & ~miso_sync;
            end
         end
         H_GAP: begin
            go = r.pend;
         end
         H_LOW: begin
            if (r.cnt == ssb_pkg::HALF_LAST) begin
               next_r.sclk = 1'b1;
               next_r.rx_sh = {r.rx_sh[6:0], miso_sync};
               next_r.cnt = 16'h0;
               next_r.st = H_HIGH;
            end
         end
         H_HIGH: begin
            if (r.cnt == ssb_pkg::HALF_LAST) begin
               next_r.sclk = 1'b0;
               next_r.cnt = 16'h0;
               next_r.bit_cnt = r.bit_cnt + 3'h1;
               next_r.tx_sh = {r.tx_sh[6:0], 1'b0};
               next_r.mosi = r.tx_sh[6];
               next_r.st = H_LOW;
               if (r.bit_cnt == ssb_pkg::BIT_LAST) begin
                  next_r.rxd = r.rx_sh;
                  next_r.pend = 1'b0;
                  ev[ssb_pkg::IRQ_DONE_BIT] = 1'b1;
                  ev[ssb_pkg::IRQ_UNDERRUN_BIT] =
                     (r.rx_sh[ssb_pkg::ST_CODE_HI:ssb_pkg::ST_CODE_LO] ==
                      ssb_pkg::CODE_UNDERRUN);
                  next_r.st = r.last ? H_HOLD : H_GAP;
               end
            end
         end
         H_HOLD: begin
            if (r.cnt == ssb_pkg::TNS_LAST) begin
               next_r.sel_low = 1'b1;
               next_r.st = H_IDLE;
            end
         end
         default: begin
            next_r.st = H_IDLE;
         end
      endcase

      // load a byte; first bit stands a full half period before rising
      if (go) begin
         next_r.tx_sh = r.txd[7:0];
         next_r.mosi = r.txd[7];
         next_r.last = r.txd[ssb_pkg::TXD_LAST_BIT];
         next_r.bit_cnt = 3'h0;
         next_r.cnt = 16'h0;
         next_r.st = H_LOW;
      end

      // data phase writes; a byte written while one is pending is dropped
      if (r.a_wr) begin
         case (r.a_addr)
            ssb_pkg::REG_TXD: begin
               if (!r.pend) begin
                  next_r.txd = hwdata[8:0];
                  next_r.pend = 1'b1;
               end
            end
            ssb_pkg::REG_CTRL: begin
               next_r.nopoll = hwdata[ssb_pkg::CTRL_NOPOLL_BIT];
            end
            ssb_pkg::REG_IRQ: begin
               next_r.irq_st = r.irq_st & ~hwdata[ssb_pkg::IRQ_W-1:0];
            end
            ssb_pkg::REG_MASK: begin
               next_r.mask = hwdata[ssb_pkg::IRQ_W-1:0];
            end
            default: begin
               next_r.nopoll = r.nopoll;
            end
         endcase
      end
      // set beats write-one-clear
      next_r.irq_st = next_r.irq_st | ev;
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= '{st: H_IDLE, sclk: 1'b0, sel_low: 1'b1, miso_s: 2'h3, default: '0};
      end else begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux; zero-wait, always okay, unmapped reads zero
   always_comb begin
      hrdata = 32'h0;
      case (r.a_addr)
         ssb_pkg::REG_TXD: hrdata[8:0] = r.txd;
         ssb_pkg::REG_RXD: hrdata[7:0] = r.rxd;
         ssb_pkg::REG_CTRL: hrdata[ssb_pkg::CTRL_NOPOLL_BIT] = r.nopoll;
         ssb_pkg::REG_STAT: begin
            hrdata[ssb_pkg::STAT_BUSY_BIT] = (r.st != H_IDLE);
            hrdata[ssb_pkg::STAT_PEND_BIT] = r.pend;
            hrdata[ssb_pkg::STAT_SEL_BIT] = ~r.sel_low;
         end
         ssb_pkg::REG_IRQ: hrdata[ssb_pkg::IRQ_W-1:0] = r.irq_st;
         ssb_pkg::REG_MASK: hrdata[ssb_pkg::IRQ_W-1:0] = r.mask;
         default: hrdata = 32'h0;
      endcase
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign irq = |(r.irq_st & r.mask);
   assign link.sclk = r.sclk;
   assign link.select_low = r.sel_low;
   assign link.mosi = r.mosi;

endmodule : ssb_status_host

// ==== tb/ssb_link_sva.sv ====
// watches the serial link between host and device
module ssb_link_sva (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic sclk,
   input wire logic select_low,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe,
   input wire logic so_line
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] HALF = 16'(ssb_pkg::SCLK_HALF_CYC);
   localparam logic [15:0] TSP = 16'(ssb_pkg::T_SP_CYC);
   logic [15:0] hi_cnt, lo_cnt, sp_cnt;
   logic clocked, sclk_q;
   logic [2:0] bits;

   ////////////////////////////////////////
   // low-half and select counters saturate so a long idle never wraps into a false alarm
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hi_cnt <= 16'h0;
         lo_cnt <= 16'h0;
         sp_cnt <= 16'h0;
         clocked <= 1'b0;
         sclk_q <= 1'b0;
         bits <= 3'h0;
      end else begin
         hi_cnt <= sclk ? hi_cnt + 16'h1 : 16'h0;
         lo_cnt <= sclk ? 16'h0 : lo_cnt + {15'h0, ~&lo_cnt};
         sp_cnt <= select_low ? 16'h0 : sp_cnt + {15'h0, ~&sp_cnt};
         clocked <= !select_low && (clocked || sclk);
         sclk_q <= sclk;
         bits <= select_low ? 3'h0 : bits + {2'h0, sclk && !sclk_q};
      end
   end

   ////////////////////////////////////////
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   chk_high_half: assert property ($fell(sclk) |-> hi_cnt >= HALF)
      else $error("serial clock high half too short");
   chk_low_half: assert property ($rose(sclk) && clocked |-> lo_cnt >= HALF)
      else $error("serial clock low half too short");
   chk_ready_first: assert property ($rose(sclk) && !clocked |-> !so_line)
      else $error("first clock edge before ready seen");
   chk_select_setup: assert property ($rose(sclk) && !clocked |-> sp_cnt >= TSP)
      else $error("select to first clock too short");
   chk_drive_off: assert property (select_low [*6] |-> !miso_oe)
      else $error("output driven while not selected");
   chk_drive_on: assert property (!select_low [*6] |-> miso_oe)
      else $error("output not driven while selected");
   chk_whole_bytes: assert property ($rose(select_low) |-> bits == 3'h0)
      else $error("select released inside a byte");
   chk_status_hold: assert property ($rose(sclk) |-> $stable(miso) [*8])
      else $error("status bit moved while clock high");
   chk_data_setup: assert property ($rose(sclk) |-> $past(mosi, 8) == mosi ##1 $stable(mosi) [*7])
      else $error("host data moved around clock rise");
endmodule : ssb_link_sva

// ==== tb/test_spi_status_byte.sv ====
module test_spi_status_byte;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int WAKE = 50;
   logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, hreadyout, irq, hresp;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0] htrans = 2'h0;
   logic crystal_not_ready = 1'b0, transitional = 1'b0, tx_queue_underrun = 1'b0;
   logic [2:0] main_state = 3'h0;
   logic [6:0] tx_free = 7'h0;
   logic rx_valid, rx_valid2, flush_tx_strobe, underrun_flag, rx_header, rx_burst, rx_rw;
   logic [5:0] rx_addr;
   logic [7:0] rx_data, rx_data2, last_rx = 8'h0, last_rx2 = 8'h0;
   logic flush_seen = 1'b0, seen = 1'b0;
   int sp = 0, sp_at = 0, cnt2 = 0, cyc = 0, fail_count = 0, cmp_count = 0;

   ssb_link_if link ();
   ssb_link_if link2 ();
   ssb_status_host #(.WAKE_CYC(WAKE)) u_ssb_status_host (
      .hclk(hclk), .hresetn(hresetn), .link(link), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));
   ssb_status_dev u_ssb_status_dev (
      .hclk(hclk), .hresetn(hresetn), .link(link), .crystal_not_ready(crystal_not_ready),
      .main_state(main_state), .state_transitional(transitional), .tx_free(tx_free),
      .tx_queue_underrun(tx_queue_underrun), .rx_valid(rx_valid), .rx_header(rx_header),
      .rx_data(rx_data), .rx_addr(rx_addr), .rx_burst(rx_burst), .rx_rw(rx_rw),
      .flush_tx_strobe(flush_tx_strobe), .underrun_flag(underrun_flag));
   // second device, bit-banged by the bench to break the framing on purpose
   ssb_status_dev u_ssb_status_dev_b (
      .hclk(hclk), .hresetn(hresetn), .link(link2), .crystal_not_ready(crystal_not_ready),
      .main_state(main_state), .state_transitional(transitional), .tx_free(tx_free),
      .tx_queue_underrun(tx_queue_underrun), .rx_valid(rx_valid2), .rx_header(),
      .rx_data(rx_data2), .rx_addr(), .rx_burst(), .rx_rw(), .flush_tx_strobe(),
      .underrun_flag());
   ssb_link_sva u_ssb_link_sva (
      .hclk(hclk), .hresetn(hresetn), .sclk(link.sclk), .select_low(link.select_low),
      .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe), .so_line(link.so_line));

   always #2 hclk = ~hclk;

   ////////////////////////////////////////
   // run ceiling, well above the roughly ten thousand cycles the tests need
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fail_count++;
         wrap_up();
      end
   end

   // user-side captures and the select-to-first-clock gap
   always @(posedge hclk) begin
      if (rx_valid === 1'b1)
         last_rx <= rx_data;
      if (rx_valid2 === 1'b1) begin
         last_rx2 <= rx_data2;
         cnt2 <= cnt2 + 1;
      end
      if (flush_tx_strobe === 1'b1)
         flush_seen <= 1'b1;
      if (link.select_low) begin
         sp <= 0;
         seen <= 1'b0;
      end else if (link.sclk && !seen) begin
         seen <= 1'b1;
         sp_at <= sp;
      end else if (!seen) begin
         sp <= sp + 1;
      end
   end

   ////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : check

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up

   // single word transfer; read data taken at the edge that ends the data phase
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
         output logic [31:0] rd);
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : xfer

   // one byte through the host, then the returned status is compared
   task automatic send(input logic [8:0] b, input logic [7:0] exp);
      logic [31:0] r;
      xfer(1'b1, ssb_pkg::REG_TXD, {23'h0, b}, r);
      r = 32'h0;
      while (r[ssb_pkg::IRQ_DONE_BIT] !== 1'b1)
         xfer(1'b0, ssb_pkg::REG_IRQ, 32'h0, r);
      xfer(1'b1, ssb_pkg::REG_IRQ, 32'h1, r);
      xfer(1'b0, ssb_pkg::REG_RXD, 32'h0, r);
      check(r, {24'h0, exp});
      // select is let go a few cycles after the last byte
      if (b[ssb_pkg::TXD_LAST_BIT])
         repeat (6) @(posedge hclk);
   endtask : send

   // bench as host on the second link, 48 ns serial period
   task automatic bang(input logic [7:0] b, input int n, output logic [7:0] so);
      link2.select_low <= 1'b0;
      repeat (6) @(posedge hclk);
      for (int i = 7; i > 7 - n; i--) begin
         link2.mosi <= b[i];
         repeat (6) @(posedge hclk);
         link2.sclk <= 1'b1;
         repeat (6) @(posedge hclk);
         so = {so[6:0], link2.so_line};
         link2.sclk <= 1'b0;
      end
      repeat (6) @(posedge hclk);
      link2.select_low <= 1'b1;
      repeat (6) @(posedge hclk);
   endtask : bang

   function automatic logic [7:0] stat(input logic [2:0] s, input logic t,
         input logic [6:0] f, input logic u);
      logic [2:0] c;
      c = s;
      if (s == 3'h1 || s == 3'h6 || (t && (s == 3'h4 || s == 3'h5)))
         c = 3'h0;
      if (u)
         c = 3'h7;
      return {1'b0, c, (f > 7'h0f) ? 4'hf : f[3:0]};
   endfunction : stat

   ////////////////////////////////////////
   initial begin
      logic [31:0] r;
      logic [7:0] so;
      link2.sclk = 1'b0;
      link2.select_low = 1'b1;
      link2.mosi = 1'b0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      // control words and three unmapped words read zero after reset
      for (int a = 8; a <= 32; a += 4) begin
         xfer(1'b0, 8'(a), 32'h0, r);
         check(r, 32'h0);
         check(hresp, 1'b0);
      end
      // host must wait while the crystal is not running
      crystal_not_ready <= 1'b1;
      tx_free <= 7'h05;
      @(posedge hclk);
      fork
         send(9'h13f, 8'h05);
         begin
            repeat (80) @(posedge hclk);
            check(link.sclk, 1'b0);
            check(link.so_line, 1'b1);
            crystal_not_ready <= 1'b0;
         end
      join
      // every state code, plain and transitional, with free counts past saturation
      for (int s = 0; s < 16; s++) begin
         main_state <= 3'(s);
         transitional <= s[3];
         tx_free <= 7'(s * 3);
         @(posedge hclk);
         send(9'h13f, stat(3'(s), s[3], 7'(s * 3), 1'b0));
      end
      // burst of queue writes; the queue takes each byte mid-slot
      main_state <= 3'h2;
      transitional <= 1'b0;
      tx_free <= 7'h10;
      @(posedge hclk);
      send(9'h07f, 8'h2f);
      for (int k = 0; k < 4; k++) begin
         fork
            send({k == 3, 8'h96 ^ 8'(k)}, stat(3'h2, 1'b0, 7'(16 - k), 1'b0));
            begin
               repeat (100) @(posedge hclk);
               tx_free <= tx_free - 7'h1;
            end
         join
         check(last_rx, 8'h96 ^ 8'(k));
      end
      // clear the code-111 event left by the raw state sweep
      xfer(1'b1, ssb_pkg::REG_IRQ, 32'h2, r);
      xfer(1'b0, ssb_pkg::REG_IRQ, 32'h0, r);
      check(r, 32'h0);
      // underrun sticks, raises a maskable flag, and clears on the flush strobe
      tx_queue_underrun <= 1'b1;
      @(posedge hclk);
      tx_queue_underrun <= 1'b0;
      send(9'h13f, 8'h7c);
      xfer(1'b0, ssb_pkg::REG_IRQ, 32'h0, r);
      check(r, 32'h2);
      check(irq, 1'b0);
      xfer(1'b1, ssb_pkg::REG_MASK, 32'h3, r);
      @(posedge hclk);
      check(irq, 1'b1);
      xfer(1'b1, ssb_pkg::REG_IRQ, 32'h2, r);
      @(posedge hclk);
      check(irq, 1'b0);
      send(9'h130, 8'h7c);
      check({flush_seen, underrun_flag}, 2'h2);
      send(9'h13f, 8'h2c);
      // blind wake wait instead of watching readiness
      xfer(1'b1, ssb_pkg::REG_CTRL, 32'h1, r);
      send(9'h13f, 8'h2c);
      check(sp_at >= WAKE, 1'b1);
      xfer(1'b1, ssb_pkg::REG_CTRL, 32'h0, r);
      // a register is rewritten while the device reports idle: header decoded, then one data byte
      main_state <= ssb_pkg::CODE_IDLE;
      @(posedge hclk);
      send(9'h00d, 8'h0c);
      check({rx_header, rx_rw, rx_burst, rx_addr}, {3'h4, 6'h0d});
      send(9'h1a5, 8'h0c);
      check({rx_header, rx_rw, rx_burst, rx_addr}, {3'h0, 6'h0d});
      check(last_rx, 8'ha5);
      // a cut byte is dropped, a whole one kept; status comes msb first
      bang(8'hc5, 4, so);
      bang(8'h3c, 8, so);
      check(cnt2, 1);
      check(last_rx2, 8'h3c);
      check(so, 8'h7c);
      wrap_up();
   end
endmodule : test_spi_status_byte
